/* rtl/fwp_pkg.sv */
// Shared constants and types for the flash write-protection block
package fwp_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SUSP_LAT_NS = 30000;
    localparam int SUSP_LAT_CYC = SUSP_LAT_NS / CLK_PERIOD_NS;
    localparam int PROG_TYP_NS = 2000000;
    localparam int PROG_MAX_NS = 3000000;
    localparam int PROG_TYP_CYC = PROG_TYP_NS / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;
    localparam int ERASE_TYP_NS = 10000000;
    localparam int ERASE_MAX_NS = 20000000;
    localparam int ERASE_TYP_CYC = ERASE_TYP_NS / CLK_PERIOD_NS;
    localparam int ERASE_MAX_CYC = ERASE_MAX_NS / CLK_PERIOD_NS;
    localparam int ARRAY_AW = 23;
    localparam int CNT_W = 22;
    localparam int LAT_W = 12;
    localparam logic [7:0] CFG_RST = 8'h40;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;
    localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_PE = 8'h81;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE = 8'h60;
    localparam logic [7:0] OP_CE2 = 8'hc7;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_RES = 8'h7a;
    localparam logic [7:0] OP_DP = 8'hb9;
    localparam logic [7:0] OP_RDP = 8'hab;
    localparam logic [4:0] EXP_PAGE = 5'h08;
    localparam logic [4:0] EXP_SECTOR = 5'h0c;
    localparam logic [4:0] EXP_BLK32 = 5'h0f;
    localparam logic [4:0] EXP_BLK64 = 5'h10;
    localparam logic [4:0] EXP_CHIP = 5'h17;
    localparam logic [4:0] EXP_FINE_BASE = 5'h0b;
    localparam logic [4:0] EXP_FINE_MAX = 5'h0f;
    localparam logic [4:0] EXP_COARSE_BASE = 5'h10;
    typedef enum logic [5:0] {
        ST_STANDBY = 6'h01,
        ST_PROGRAM = 6'h02,
        ST_ERASE = 6'h04,
        ST_SUSPENDING = 6'h08,
        ST_SUSPENDED = 6'h10,
        ST_DEEP_PD = 6'h20
    } state_t;
    typedef struct packed {
        logic protect_granularity_bit;
        logic protect_bottom_select;
        logic protect_size_bit2;
        logic protect_size_bit1;
        logic protect_size_bit0;
    } prot_t;
    typedef struct packed {
        logic status_protect_bit_high;
        logic status_protect_bit_low;
        prot_t prot;
        logic write_enable_latch_bit;
    } stat_t;
    typedef struct packed {
        logic individual_lock_select;
        logic complement_protect_bit;
    } ctrl_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [6:0] shift;
        logic [2:0] nbytes;
        logic [2:0] phase;
    } frame_t;
endpackage : fwp_pkg

/* rtl/link_sync.sv */
// Two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ps
module link_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else if (ce_i) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign sync_o = sync_q;
endmodule : link_sync

/* rtl/protect_decode.sv */
// Block-protect decode: tells whether an address range touches the protected area
`timescale 1ns/1ps
module protect_decode import fwp_pkg::*; (
    input wire prot_t prot_i,
    input wire logic alt_map_i,
    input wire logic [ARRAY_AW-1:0] lo_i,
    input wire logic [ARRAY_AW-1:0] hi_i,
    output logic hit_o
);
    logic [2:0] code;
    logic [4:0] size_e;
    logic [ARRAY_AW-1:0] mask;
    logic [ARRAY_AW-1:0] plo;
    logic [ARRAY_AW-1:0] phi;
    logic none_p;
    logic all_p;
    always_comb begin
        code = {prot_i.protect_size_bit2, prot_i.protect_size_bit1, prot_i.protect_size_bit0};
        none_p = (code == 3'h0);
        all_p = (code == 3'h7);
        if (prot_i.protect_granularity_bit) begin
            // Codes 100, 101 and 110 all give the largest fine size
            size_e = code[2] ? EXP_FINE_MAX : EXP_FINE_BASE + {2'h0, code};
        end else begin
            size_e = EXP_COARSE_BASE + {2'h0, code};
        end
        mask = ~({ARRAY_AW{1'b1}} << size_e);
        if (prot_i.protect_bottom_select) begin
            plo = '0;
            phi = mask;
        end else begin
            plo = ~mask;
            phi = {ARRAY_AW{1'b1}};
        end
        // Other maps are not decoded here, so they fail safe as fully locked
        hit_o = alt_map_i | (~none_p & (all_p | ((lo_i <= phi) & (hi_i >= plo))));
    end
endmodule : protect_decode

/* rtl/flash_write_protection.sv */
// Write protection, command gating and program/erase timing of a serial flash
//
// Overview of operation
// - Suspend completes and device becomes ready within 30 us.
// - Page program keeps device busy typically 2 ms, at most 3 ms.
// - Every erase keeps device busy typically 10 ms, at most 20 ms.
// - Reset forces the control state machine into standby.
// - After reset status reads 00h and configuration reads 40h.
// - Commands not ending on a byte boundary are rejected.
// - Data-changing commands need the write-enable latch set first.
// - Block-protect bits select a read-only region of the array.
// - Write-protect pin low freezes protect and status-protect bits.
// - Deep power-down ignores every aligned command except its release command.
// - Coarse mode protects 1/64 to 1/2, top or bottom, 000 none, 111 all.
// - Fine mode protects 4, 8, 16 or 32 KB at top or bottom.
// - Program or erase touching any protected byte is dropped entirely.
`timescale 1ns/1ps
module flash_write_protection import fwp_pkg::*; #(
    parameter int PROG_CYC = PROG_TYP_CYC,
    parameter int ERASE_CYC = ERASE_TYP_CYC
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic busy_o,
    output logic deep_pd_o,
    output logic program_go_o,
    output logic erase_go_o,
    output logic reject_o,
    output logic [ARRAY_AW-1:0] op_addr_o
);
    logic [3:0] pin_s;
    logic cs_s;
    logic sclk_s;
    logic si_s;
    logic wp_s;
    logic cs_d_q;
    logic cs_d_d;
    logic sclk_d_q;
    logic sclk_d_d;
    frame_t fr_q;
    frame_t fr_d;
    logic [7:0] byte_w;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic fr_end;
    logic aligned;
    state_t state_q;
    state_t state_d;
    stat_t stat_q;
    stat_t stat_d;
    logic [CNT_W-1:0] op_cnt_q;
    logic [CNT_W-1:0] op_cnt_d;
    logic [LAT_W-1:0] lat_cnt_q;
    logic [LAT_W-1:0] lat_cnt_d;
    logic susp_erase_q;
    logic susp_erase_d;
    logic busy_q;
    logic busy_d;
    logic dpd_q;
    logic dpd_d;
    logic prog_go_q;
    logic prog_go_d;
    logic erase_go_q;
    logic erase_go_d;
    logic reject_q;
    logic reject_d;
    logic [ARRAY_AW-1:0] op_addr_q;
    logic [ARRAY_AW-1:0] op_addr_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    ctrl_t ctrl_q;
    ctrl_t ctrl_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic is_array;
    logic is_erase;
    logic [2:0] need;
    logic [4:0] rng_e;
    logic [ARRAY_AW-1:0] rng_mask;
    logic [ARRAY_AW-1:0] rng_lo;
    logic [ARRAY_AW-1:0] rng_hi;
    logic hit_w;

    link_sync #(.WIDTH(4), .RST_VAL(4'h9)) u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .async_i({wp_n_i, si_i, sclk_i, cs_n_i}),
        .sync_o(pin_s)
    );
    assign cs_s = pin_s[0];
    assign sclk_s = pin_s[1];
    assign si_s = pin_s[2];
    assign wp_s = pin_s[3];
    assign cs_fall = cs_d_q & ~cs_s;
    assign cs_rise = ~cs_d_q & cs_s;
    assign sclk_rise = ~sclk_d_q & sclk_s & ~cs_s;
    assign fr_end = cs_rise;
    assign aligned = (fr_q.phase == 3'h0) && (fr_q.nbytes != 3'h0);

    // Serial frame capture; only the first four bytes are kept
    always_comb begin
        cs_d_d = cs_s;
        sclk_d_d = sclk_s;
        fr_d = fr_q;
        byte_w = {fr_q.shift, si_s};
        if (cs_fall) begin
            fr_d = '0;
        end else if (sclk_rise) begin
            fr_d.shift = byte_w[6:0];
            fr_d.phase = fr_q.phase + 3'h1;
            if (fr_q.phase == 3'h7) begin
                if (fr_q.nbytes != 3'h7) begin
                    fr_d.nbytes = fr_q.nbytes + 3'h1;
                end
                case (fr_q.nbytes)
                    3'h0: fr_d.opcode = byte_w;
                    3'h1: fr_d.addr[23:16] = byte_w;
                    3'h2: fr_d.addr[15:8] = byte_w;
                    3'h3: fr_d.addr[7:0] = byte_w;
                    default: fr_d.shift = byte_w[6:0];
                endcase
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cs_d_q <= 1'b1;
            sclk_d_q <= 1'b0;
            fr_q <= '0;
        end else if (ce_i) begin
            cs_d_q <= cs_d_d;
            sclk_d_q <= sclk_d_d;
            fr_q <= fr_d;
        end
    end

    // Target range of an array command
    always_comb begin
        is_array = 1'b1;
        is_erase = 1'b1;
        need = 3'h4;
        rng_e = EXP_PAGE;
        case (fr_q.opcode)
            OP_PP: is_erase = 1'b0;
            OP_PE: rng_e = EXP_PAGE;
            OP_SE: rng_e = EXP_SECTOR;
            OP_BE32: rng_e = EXP_BLK32;
            OP_BE64: rng_e = EXP_BLK64;
            OP_CE, OP_CE2: begin
                rng_e = EXP_CHIP;
                need = 3'h1;
            end
            default: begin
                is_array = 1'b0;
                is_erase = 1'b0;
            end
        endcase
        rng_mask = ~({ARRAY_AW{1'b1}} << rng_e);
        rng_lo = fr_q.addr[ARRAY_AW-1:0] & ~rng_mask;
        rng_hi = rng_lo | rng_mask;
    end

    protect_decode u_decode (
        .prot_i(stat_q.prot),
        .alt_map_i(ctrl_q.complement_protect_bit | ctrl_q.individual_lock_select),
        .lo_i(rng_lo),
        .hi_i(rng_hi),
        .hit_o(hit_w)
    );

    // Command execution and operation timing
    always_comb begin
        state_d = state_q;
        stat_d = stat_q;
        op_cnt_d = op_cnt_q;
        lat_cnt_d = lat_cnt_q;
        susp_erase_d = susp_erase_q;
        op_addr_d = op_addr_q;
        prog_go_d = 1'b0;
        erase_go_d = 1'b0;
        reject_d = 1'b0;
        case (state_q)
            ST_PROGRAM, ST_ERASE: begin
                if (op_cnt_q <= CNT_W'(1)) begin
                    state_d = ST_STANDBY;
                end else begin
                    op_cnt_d = op_cnt_q - CNT_W'(1);
                end
            end
            ST_SUSPENDING: begin
                if (lat_cnt_q <= LAT_W'(1)) begin
                    state_d = ST_SUSPENDED;
                end else begin
                    lat_cnt_d = lat_cnt_q - LAT_W'(1);
                end
            end
            default: state_d = state_q;
        endcase
        if (fr_end) begin
            if (!aligned) begin
                reject_d = 1'b1;
            end else begin
                case (state_q)
                    ST_DEEP_PD: begin
                        if (fr_q.opcode == OP_RDP) begin
                            state_d = ST_STANDBY;
                        end
                    end
                    ST_PROGRAM, ST_ERASE: begin
                        // Other commands are ignored while the array is busy
                        if (fr_q.opcode == OP_SUSP) begin
                            state_d = ST_SUSPENDING;
                            lat_cnt_d = LAT_W'(SUSP_LAT_CYC - 1);
                            susp_erase_d = (state_q == ST_ERASE);
                        end
                    end
                    ST_STANDBY, ST_SUSPENDED: begin
                        if (fr_q.opcode == OP_WRITE_ENABLE_COMMAND) begin
                            stat_d.write_enable_latch_bit = 1'b1;
                        end else if (fr_q.opcode == OP_WRDI) begin
                            stat_d.write_enable_latch_bit = 1'b0;
                        end else if (fr_q.opcode == OP_RES && state_q == ST_SUSPENDED) begin
                            state_d = susp_erase_q ? ST_ERASE : ST_PROGRAM;
                        end else if (fr_q.opcode == OP_DP && state_q == ST_STANDBY) begin
                            state_d = ST_DEEP_PD;
                        end else if (fr_q.opcode == OP_WRSR) begin
                            if (!stat_q.write_enable_latch_bit || fr_q.nbytes < 3'h2 || !wp_s) begin
                                reject_d = 1'b1;
                            end else begin
                                stat_d.write_enable_latch_bit = 1'b0;
                                stat_d.status_protect_bit_low = fr_q.addr[23];
                                stat_d.prot = prot_t'(fr_q.addr[22:18]);
                                if (fr_q.nbytes >= 3'h3) begin
                                    stat_d.status_protect_bit_high = fr_q.addr[8];
                                end
                            end
                        end else if (is_array) begin
                            stat_d.write_enable_latch_bit = 1'b0;
                            if (!stat_q.write_enable_latch_bit || state_q != ST_STANDBY
                                || fr_q.nbytes < need || hit_w) begin
                                reject_d = 1'b1;
                            end else begin
                                state_d = is_erase ? ST_ERASE : ST_PROGRAM;
                                op_cnt_d = is_erase ? CNT_W'(ERASE_CYC) : CNT_W'(PROG_CYC);
                                op_addr_d = rng_lo;
                                prog_go_d = ~is_erase;
                                erase_go_d = is_erase;
                            end
                        end
                    end
                    default: state_d = state_q;
                endcase
            end
        end
        busy_d = (state_d == ST_PROGRAM) || (state_d == ST_ERASE) || (state_d == ST_SUSPENDING);
        dpd_d = (state_d == ST_DEEP_PD);
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= ST_STANDBY;
            stat_q <= stat_t'(STATUS_RST);
            op_cnt_q <= '0;
            lat_cnt_q <= '0;
            susp_erase_q <= 1'b0;
            op_addr_q <= '0;
            prog_go_q <= 1'b0;
            erase_go_q <= 1'b0;
            reject_q <= 1'b0;
            busy_q <= 1'b0;
            dpd_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            stat_q <= stat_d;
            op_cnt_q <= op_cnt_d;
            lat_cnt_q <= lat_cnt_d;
            susp_erase_q <= susp_erase_d;
            op_addr_q <= op_addr_d;
            prog_go_q <= prog_go_d;
            erase_go_q <= erase_go_d;
            reject_q <= reject_d;
            busy_q <= busy_d;
            dpd_q <= dpd_d;
        end
    end

    // Register port; read data stand only in the cycle after the strobe
    always_comb begin
        cfg_d = cfg_q;
        ctrl_d = ctrl_q;
        rdata_d = '0;
        if (reg_wr_i) begin
            if (reg_addr_i == REG_CONFIG) begin
                cfg_d = reg_wdata_i[7:0];
            end else if (reg_addr_i == REG_CTRL) begin
                ctrl_d = ctrl_t'(reg_wdata_i[1:0]);
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == REG_STATUS) begin
                rdata_d = {7'h00, stat_q, busy_q};
            end else if (reg_addr_i == REG_CONFIG) begin
                rdata_d = {8'h00, cfg_q};
            end else if (reg_addr_i == REG_CTRL) begin
                rdata_d = {14'h0000, ctrl_q};
            end else if (reg_addr_i == REG_STATE) begin
                rdata_d = {10'h000, state_q};
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cfg_q <= CFG_RST;
            ctrl_q <= '0;
            rdata_q <= '0;
        end else if (ce_i) begin
            cfg_q <= cfg_d;
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign busy_o = busy_q;
    assign deep_pd_o = dpd_q;
    assign program_go_o = prog_go_q;
    assign erase_go_o = erase_go_q;
    assign reject_o = reject_q;
    assign op_addr_o = op_addr_q;

    // Helper: cycles spent finishing a suspend
    logic [LAT_W-1:0] susp_age_q;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            susp_age_q <= '0;
        end else if (ce_i) begin
            susp_age_q <= (state_q == ST_SUSPENDING) ? susp_age_q + LAT_W'(1) : '0;
        end
    end

    chk_susp_latency: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        state_q == ST_SUSPENDING |-> susp_age_q <= LAT_W'(SUSP_LAT_CYC - 2))
        else $error("suspend took longer than its latency");
    chk_wel_gate: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        $rose(program_go_o) || $rose(erase_go_o) |-> $past(stat_q.write_enable_latch_bit))
        else $error("array operation started without write enable");
    chk_protect_block: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        $rose(program_go_o) || $rose(erase_go_o) |-> !$past(hit_w))
        else $error("array operation started on protected range");
    chk_wp_freeze: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !wp_s |=> $stable(stat_q.prot) && $stable(stat_q.status_protect_bit_low)
            && $stable(stat_q.status_protect_bit_high))
        else $error("protect bits changed with write protect low");
    chk_deep_pd_ignore: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        state_q == ST_DEEP_PD |=> !$rose(program_go_o) && !$rose(erase_go_o) && !busy_o)
        else $error("command acted during deep power-down");
    chk_byte_bound: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && fr_end && !aligned |=> reject_o && !$rose(program_go_o) && $stable(stat_q))
        else $error("misaligned command was not rejected");
    chk_busy_flag: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        busy_o == (state_q inside {ST_PROGRAM, ST_ERASE, ST_SUSPENDING}))
        else $error("busy does not match pending operation");
    chk_reset_state: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        srst_i |=> state_q == ST_STANDBY && cfg_q == CFG_RST && stat_q == stat_t'(STATUS_RST))
        else $error("reset did not restore delivery state");
    chk_prog_time: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        state_q == ST_PROGRAM |-> op_cnt_q <= CNT_W'(PROG_CYC) && op_cnt_q != '0)
        else $error("program counter out of range");
    chk_erase_time: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        $rose(erase_go_o) |-> state_q == ST_ERASE && op_cnt_q == CNT_W'(ERASE_CYC))
        else $error("erase did not load its busy time");

    cov_suspend_resume: cover property (
        @(posedge clk_sys_i) disable iff (srst_i)
        state_q == ST_SUSPENDED ##1 state_q == ST_PROGRAM);
    cov_erase_start: cover property (
        @(posedge clk_sys_i) disable iff (srst_i) $rose(erase_go_o));
    cov_protect_reject: cover property (
        @(posedge clk_sys_i) disable iff (srst_i) fr_end && aligned && is_array && hit_w);
    cov_deep_pd_exit: cover property (
        @(posedge clk_sys_i) disable iff (srst_i)
        state_q == ST_DEEP_PD ##1 state_q == ST_STANDBY);
endmodule : flash_write_protection

/* test/spi_host_model.sv */
// Host serial master model that frames commands for the protection block
`timescale 1ns/1ps
module spi_host_model import fwp_pkg::*; (
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    realtime last_resume_t = -1.0e9;
    initial begin
        cs_n_o = 1'b1; // Deselected while the supply ramps
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    // Clock stands low outside frames; data line inverts once released
    task automatic send(input logic [31:0] v, input int nbits);
        if (v[31:24] == OP_SUSP) begin
            while ($realtime - last_resume_t < 350000.0) #1000; // Resume-to-suspend gap
        end
        if ($realtime < 70000.0) #(70000.0 - $realtime); // Select only after the power-up delay
        // Quarter-nanosecond skew keeps every pin change off a system clock edge
        #0.25 cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si_o = v[31-i];
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        si_o = ~si_o;
        if (v[31:24] == OP_RES) last_resume_t = $realtime;
    endtask : send
endmodule : spi_host_model

/* test/tb_top.sv */
// Self-checking bench for the flash write-protection block
`timescale 1ns/1ps
module tb_top import fwp_pkg::*;;
    logic clk_sys_i = 0, srst_i = 1, ce_i = 1, wp_n_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic [3:0] reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0, reg_rdata_o;
    logic busy_o, deep_pd_o, program_go_o, erase_go_o, reject_o, cs_n, sclk, si;
    logic [ARRAY_AW-1:0] op_addr_o;
    int num_errors = 0, tests_run = 0, n_rej = 0, n_era = 0, n_prg = 0, r0, e0, p0;
    // Status byte, target address, refusal expected
    logic [32:0] tbl [10] = '{{8'h04, 24'h7f0000, 1'b1}, {8'h04, 24'h7d0000, 1'b0}, {8'h24, 24'h01f000, 1'b1},
        {8'h24, 24'h020000, 1'b0}, {8'h1c, 24'h000000, 1'b1}, {8'h44, 24'h7ff000, 1'b1},
        {8'h44, 24'h7fe000, 1'b0}, {8'h64, 24'h000000, 1'b1}, {8'h64, 24'h001000, 1'b0},
        {8'h00, 24'h7f0000, 1'b0}};
    always #4 clk_sys_i = ~clk_sys_i;
    // Pulses are counted so a check never depends on landing in the exact cycle
    always @(posedge clk_sys_i) begin
        n_rej <= n_rej + int'(reject_o === 1'b1);
        n_era <= n_era + int'(erase_go_o === 1'b1);
        n_prg <= n_prg + int'(program_go_o === 1'b1);
    end
    flash_write_protection #(.PROG_CYC(20), .ERASE_CYC(4000)) i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .ce_i(ce_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .wp_n_i(wp_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .busy_o(busy_o), .deep_pd_o(deep_pd_o), .program_go_o(program_go_o), .erase_go_o(erase_go_o),
        .reject_o(reject_o), .op_addr_o(op_addr_o));
    spi_host_model i_host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk("register read", exp, reg_rdata_o);
    endtask : rd
    // A bound that runs out is a mismatch and ends the run at once
    task automatic idle(input int lim);
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < lim) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("busy within bound", 1, n < lim);
        if (n >= lim) complete_run();
    endtask : idle
    task automatic frame(input logic [31:0] v, input int nb, input logic rej, input logic wt);
        r0 = n_rej;
        e0 = n_era;
        i_host.send(v, nb);
        repeat (8) @(posedge clk_sys_i);
        chk("reject pulses", rej, n_rej - r0);
        if (wt) idle(6000);
    endtask : frame
    initial begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rd(REG_STATUS, 16'h0000);
        rd(REG_CONFIG, 16'h0040);
        rd(REG_STATE, 16'h0001);
        wr(REG_CONFIG, 16'h00a5);
        rd(REG_CONFIG, 16'h00a5);
        frame({OP_PP, 24'h000100}, 32, 1, 1);
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        rd(REG_STATUS, 16'h0002);
        frame({OP_WRDI, 24'h0}, 8, 0, 1);
        frame({OP_PP, 24'h000100}, 32, 1, 1);
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_SE, 24'h001234}, 28, 1, 1);
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_SE, 24'h001234}, 32, 0, 0);
        chk("erase go", 1, n_era - e0);
        chk("op address", 23'h001000, op_addr_o);
        chk("busy", 1, busy_o);
        idle(4100);
        p0 = n_prg;
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_PP, 24'h000100}, 32, 0, 0);
        chk("program go", 1, n_prg - p0);
        idle(40);
        for (int i = 0; i < 10; i++) begin
            frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
            frame({OP_WRSR, tbl[i][32:25], 16'h0}, 16, 0, 1);
            rd(REG_STATUS, {8'h00, tbl[i][32:25]});
            frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
            frame({OP_SE, tbl[i][24:1]}, 32, tbl[i][0], 1);
        end
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_CE, 24'h0}, 8, 0, 1);
        chk("erase go", 1, n_era - e0);
        chk("op address", 23'h000000, op_addr_o);
        wr(REG_CTRL, 16'h0001);
        rd(REG_CTRL, 16'h0001);
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_SE, 24'h400000}, 32, 1, 1);
        wr(REG_CTRL, 16'h0002);
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_BE64, 24'h400000}, 32, 1, 1);
        wr(REG_CTRL, 16'h0000);
        @(posedge clk_sys_i) wp_n_i <= 1'b0;
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_WRSR, 8'h04, 16'h0}, 16, 1, 1);
        rd(REG_STATUS, 16'h0002);
        @(posedge clk_sys_i) wp_n_i <= 1'b1;
        frame({OP_DP, 24'h0}, 8, 0, 1);
        chk("deep power-down", 1, deep_pd_o);
        p0 = n_prg;
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_PP, 24'h000100}, 32, 0, 1);
        chk("program in deep power-down", 0, n_prg - p0);
        frame({OP_RDP, 24'h0}, 8, 0, 1);
        chk("deep power-down", 0, deep_pd_o);
        frame({OP_WRITE_ENABLE_COMMAND, 24'h0}, 8, 0, 1);
        frame({OP_SE, 24'h400000}, 32, 0, 0);
        // A frozen clock enable must hold the erase count well past its length
        ce_i <= 1'b0;
        repeat (4100) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        chk("busy while frozen", 1, busy_o);
        frame({OP_SUSP, 24'h0}, 8, 0, 0);
        chk("busy while suspending", 1, busy_o);
        idle(SUSP_LAT_CYC);
        rd(REG_STATE, 16'h0010);
        frame({OP_RES, 24'h0}, 8, 0, 0);
        chk("busy after resume", 1, busy_o);
        idle(4100);
        complete_run();
    end
endmodule : tb_top
